// *** tile_status_control_regs.sv ***
// processor status register bank of one tile: control, boot, security, ring oscillators
//
// Operation
// [R1] tx data delayed by delay field cycles
// [R2] tx clock high at divider, low at half
// [R3] software programs divider as ratio minus one
// [R4] rgmii reaches ports only while enabled
// [R5] dynamic divider only when all threads paused
// [R6] divider enable bit requests low-power division
// [R7] boot status reports tile processor number
// [R8] boot status reports ram, jtag, pll straps
// [R9] boot status reports second core powered
// [R10] security register loaded from otp word
// [R11] access-disable bit locks security register writes
// [R12] disable bits block global and jtag debug
// [R13] secure boot override, pll/boot jtag block
// [R14] redundancy bit enables otp redundancy
// [R15] four oscillators, each counting, software controlled
// [R16] read counts ten cycles after stopping
// [R17] oscillator control: core and periph enables
// [R18] 16-bit counts, kept across reset
// [R19] counts ordered tile cell, wire, periph cell
// [R20] oscillators asynchronous to the tile clock
// [R21] register id is number shl 8 or 0x0b
// [R22] fourth count is peripheral wire oscillator
// [R23] divider counter wraps after reaching value
// [R24] counters step on edges only while enabled
`timescale 1ns/1ns
module tile_status_control_regs #(
  parameter int DELAY_DEPTH = 256
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_in,
  input  wire tile_status_pkg::ps_req_t      ps_req_in,
  output logic [31:0]                        ps_rdata_out,
  output logic                               ps_rvalid_out,
  input  wire tile_status_pkg::rgmii_tx_t    rgmii_tx_in,
  output tile_status_pkg::rgmii_tx_t         rgmii_tx_out,
  output logic                               rgmii_tx_clk_out,
  output logic                               rgmii_port_en_out,
  input  wire logic                          threads_paused_in,
  output logic                               clk_div_active_out,
  input  wire logic [7:0]                    processor_number_in,
  input  wire logic                          boot_from_ram_in,
  input  wire logic                          boot_from_jtag_in,
  input  wire logic                          second_core_powered_in,
  input  wire logic [1:0]                    boot_pll_strap_in,
  input  wire logic                          otp_load_in,
  input  wire logic [31:0]                   otp_word_in,
  output tile_status_pkg::security_ctl_t     security_ctl_out,
  input  wire logic [3:0]                    osc_in,
  output logic [1:0]                         osc_run_out
);
  import tile_status_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [31:0] masked_write(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [31:0] mask);
    masked_write = (old_v & ~mask) | (new_v & mask);
  endfunction : masked_write

  function automatic logic hit(input ps_req_t r, input logic [7:0] num);
    hit = r.wr && (r.num == num);
  endfunction : hit

  logic [31:0]            tile_ctrl_q;
  logic [31:0]            security_q;
  logic [1:0]             osc_ctrl_q;
  logic [1:0]             strap_s1_q;
  logic [1:0]             strap_s2_q;
  logic [1:0]             strap_s3_q;
  logic [1:0]             boot_pll_strap_q;
  logic [2:0]             settle_q;
  logic [31:0]            boot_status;
  logic [31:0]            rdata_d;
  logic [31:0]            rdata_q;
  logic                   rvalid_q;
  logic [TXD_DELAY_W-1:0] txd_delay;
  logic [TXC_DIV_W-1:0]   txc_div;
  logic [TXC_DIV_W-1:0]   txc_cnt_q;
  logic                   txc_q;
  logic [7:0]             wr_ptr_q;
  logic [7:0]             rd_ptr;
  rgmii_tx_t              delay_mem [DELAY_DEPTH];
  rgmii_tx_t              tx_q;
  logic [OSC_COUNT_W-1:0] osc_count [OSC_COUNT_NUM];

  assign txd_delay = tile_ctrl_q[TXD_DELAY_LSB +: TXD_DELAY_W];
  assign txc_div   = tile_ctrl_q[TXC_DIV_LSB +: TXC_DIV_W];

  // ==========================================================
  // tile control register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tile_ctrl_q <= TILE_CTRL_RESET;
    end else if (hit(ps_req_in, NUM_TILE_CTRL)) begin
      tile_ctrl_q <= masked_write(tile_ctrl_q, ps_req_in.wdata, TILE_CTRL_MASK);
    end
  end

  // ==========================================================
  // security configuration: otp copy wins over software, lock blocks software only
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      security_q <= SEC_RESET;
    end else if (otp_load_in) begin
      security_q <= otp_word_in & SEC_MASK; // R10
    end else if (hit(ps_req_in, NUM_SECURITY) && !security_q[SEC_LOCK_BIT]) begin // R11
      security_q <= masked_write(security_q, ps_req_in.wdata, SEC_MASK);
    end
  end

  assign security_ctl_out.global_debug_block = security_q[SEC_GDBG_BIT];    // R12
  assign security_ctl_out.jtag_debug_block   = security_q[SEC_JTAGDBG_BIT]; // R12
  assign security_ctl_out.secure_boot        = security_q[SEC_SBOOT_BIT];   // R13
  assign security_ctl_out.pll_jtag_block     = security_q[SEC_PLLJTAG_BIT]; // R13
  assign security_ctl_out.otp_redundancy     = security_q[SEC_REDUND_BIT];  // R14

  // ==========================================================
  // oscillator control
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_ctrl_q <= OSC_CTRL_RESET;
    end else if (hit(ps_req_in, NUM_OSC_CTRL)) begin
      osc_ctrl_q <= ps_req_in.wdata[1:0]; // R17
    end
  end

  assign osc_run_out = osc_ctrl_q;

  // counters 0,1 are the tile oscillators, 2,3 the peripheral ones
  for (genvar i = 0; i < OSC_COUNT_NUM; i++) begin : g_osc
    ring_osc_counter #(
      .COUNT_W (OSC_COUNT_W)
    ) u_osc (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .osc_in      (osc_in[i]),                                       // R20
      .run_in      (osc_ctrl_q[(i < 2) ? OSC_CORE_BIT : OSC_PERIPH_BIT]), // R15
      .count_out   (osc_count[i])
    );
  end

  // ==========================================================
  // pll mode straps: synchronised, then frozen once they have settled after reset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      strap_s3_q <= 2'h0;
    end else begin
      strap_s1_q <= boot_pll_strap_in;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      settle_q         <= 3'h0;
      boot_pll_strap_q <= 2'h0;
    end else if (settle_q != 3'(STRAP_SETTLE + 1)) begin
      // the synchroniser needs three edges to fill, so the window runs one edge past that
      settle_q <= settle_q + 3'h1;
      if (strap_s2_q == strap_s3_q) begin
        boot_pll_strap_q <= strap_s3_q; // R8
      end
    end
  end

  always_comb begin
    boot_status                                    = 32'h0000_0000;
    boot_status[BOOT_PROC_LSB +: 8]                = processor_number_in;    // R7
    boot_status[BOOT_SECURE_BIT]                   = security_q[SEC_SBOOT_BIT];
    boot_status[BOOT_CORE1_BIT]                    = second_core_powered_in; // R9
    boot_status[BOOT_RAM_BIT]                      = boot_from_ram_in;       // R8
    boot_status[BOOT_JTAG_BIT]                     = boot_from_jtag_in;      // R8
    boot_status[1:0]                               = boot_pll_strap_q;       // R8
  end

  // ==========================================================
  // read port: one cycle after the request, unmapped numbers read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (ps_req_in.num)
      NUM_TILE_CTRL:   rdata_d = tile_ctrl_q;
      NUM_BOOT_STATUS: rdata_d = boot_status;
      NUM_SECURITY:    rdata_d = security_q;
      NUM_OSC_CTRL:    rdata_d = {30'h0, osc_ctrl_q};
      NUM_OSC_COUNT0:          rdata_d = {16'h0, osc_count[0]}; // R19
      NUM_OSC_COUNT0 + 8'h01:  rdata_d = {16'h0, osc_count[1]}; // R19
      NUM_OSC_COUNT0 + 8'h02:  rdata_d = {16'h0, osc_count[2]}; // R19
      NUM_OSC_COUNT0 + 8'h03:  rdata_d = {16'h0, osc_count[3]}; // R22
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= ps_req_in.rd;
      if (ps_req_in.rd) begin
        rdata_q <= rdata_d; // R18
      end
    end
  end

  assign ps_rdata_out  = rdata_q;
  assign ps_rvalid_out = rvalid_q;

  // ==========================================================
  // transmit clock divider; ratio is field plus one, so odd fields give even splits
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      txc_cnt_q <= '0;
    end else if (txc_cnt_q >= txc_div) begin
      txc_cnt_q <= '0; // R23
    end else begin
      txc_cnt_q <= txc_cnt_q + TXC_DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      txc_q <= 1'b0;
    end else if (txc_cnt_q == txc_div) begin
      txc_q <= 1'b1; // R2
    end else if (txc_cnt_q == (txc_div >> 1)) begin
      txc_q <= 1'b0; // R2
    end
  end

  // ==========================================================
  // transmit data delay line; one output register adds a fixed cycle
  assign rd_ptr = wr_ptr_q - txd_delay;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= 8'h00;
    end else begin
      wr_ptr_q <= wr_ptr_q + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    delay_mem[wr_ptr_q] <= rgmii_tx_in;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_q <= '0;
    end else if (txd_delay == '0) begin
      tx_q <= rgmii_tx_in; // R1
    end else begin
      tx_q <= delay_mem[rd_ptr]; // R1
    end
  end

  // ==========================================================
  // port gating and low-power divider request
  assign rgmii_port_en_out  = tile_ctrl_q[RGMII_EN_BIT];
  assign rgmii_tx_out       = tile_ctrl_q[RGMII_EN_BIT] ? tx_q : '0; // R4
  assign rgmii_tx_clk_out   = tile_ctrl_q[RGMII_EN_BIT] & txc_q;     // R4
  assign clk_div_active_out = tile_ctrl_q[DIV_EN_BIT] &                // R6
                              (~tile_ctrl_q[DIV_DYN_BIT] | threads_paused_in); // R5

  // ==========================================================
  // checks
  a_txc_rise: assert property (@(posedge core_clk_in) disable iff (rst_in) // R2
    (txc_cnt_q == txc_div) |=> txc_q)
    else $error("tx clock did not rise at divider value");

  a_txc_wrap: assert property (@(posedge core_clk_in) disable iff (rst_in) // R23
    (txc_cnt_q == txc_div) |=> txc_cnt_q == '0)
    else $error("divider counter did not wrap");

  a_port_gate: assert property (@(posedge core_clk_in) disable iff (rst_in) // R4
    !tile_ctrl_q[RGMII_EN_BIT] |-> (rgmii_tx_out == '0) && !rgmii_tx_clk_out)
    else $error("rgmii drove ports while disabled");

  a_div_dynamic: assert property (@(posedge core_clk_in) disable iff (rst_in) // R5
    (tile_ctrl_q[DIV_DYN_BIT] && !threads_paused_in) |-> !clk_div_active_out)
    else $error("dynamic divider active with running threads");

  a_div_static: assert property (@(posedge core_clk_in) disable iff (rst_in) // R6
    (tile_ctrl_q[DIV_EN_BIT] && !tile_ctrl_q[DIV_DYN_BIT]) |-> clk_div_active_out)
    else $error("static divider not active");

  a_sec_lock: assert property (@(posedge core_clk_in) disable iff (rst_in) // R11
    (security_q[SEC_LOCK_BIT] && !otp_load_in) |=> security_q == $past(security_q))
    else $error("locked security register changed");

  a_sec_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10
    otp_load_in |=> security_q == ($past(otp_word_in) & SEC_MASK))
    else $error("security register not loaded from otp");

  a_delay_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
    (txd_delay == '0) ##1 (txd_delay == '0) |-> tx_q == $past(rgmii_tx_in))
    else $error("zero delay did not pass data next cycle");

  a_read_ctrl: assert property (@(posedge core_clk_in) disable iff (rst_in) // R17
    (ps_req_in.rd && ps_req_in.num == NUM_OSC_CTRL && !ps_req_in.wr)
      |=> ps_rvalid_out && ps_rdata_out == {30'h0, osc_ctrl_q})
    else $error("oscillator control read back wrong");

endmodule : tile_status_control_regs

// *** tile_status_pkg.sv ***
// shared constants and carriers for the tile status register bank
package tile_status_pkg;

  // ==========================================================
  // register numbers
  localparam logic [7:0] NUM_TILE_CTRL   = 8'h02;
  localparam logic [7:0] NUM_BOOT_STATUS = 8'h03;
  localparam logic [7:0] NUM_SECURITY    = 8'h05;
  localparam logic [7:0] NUM_OSC_CTRL    = 8'h06;
  localparam logic [7:0] NUM_OSC_COUNT0  = 8'h07;
  localparam int         OSC_COUNT_NUM   = 4;

  // ==========================================================
  // tile control fields
  localparam int TXD_DELAY_LSB = 18;
  localparam int TXD_DELAY_W   = 8;
  localparam int TXC_DIV_LSB   = 9;
  localparam int TXC_DIV_W     = 9;
  localparam int RGMII_EN_BIT  = 8;
  localparam int DIV_DYN_BIT   = 5;
  localparam int DIV_EN_BIT    = 4;
  localparam logic [31:0] TILE_CTRL_MASK  = 32'h03ff_ff30;
  localparam logic [31:0] TILE_CTRL_RESET = 32'h0000_0000;

  // ==========================================================
  // boot status fields
  localparam int BOOT_PROC_LSB   = 16;
  localparam int BOOT_SECURE_BIT = 8;
  localparam int BOOT_CORE1_BIT  = 5;
  localparam int BOOT_RAM_BIT    = 3;
  localparam int BOOT_JTAG_BIT   = 2;
  localparam int STRAP_SETTLE    = 3;

  // ==========================================================
  // security configuration fields
  localparam int SEC_LOCK_BIT     = 31;
  localparam int SEC_GDBG_BIT     = 14;
  localparam int SEC_REDUND_BIT   = 7;
  localparam int SEC_SBOOT_BIT    = 5;
  localparam int SEC_PLLJTAG_BIT  = 4;
  localparam int SEC_JTAGDBG_BIT  = 0;
  localparam logic [31:0] SEC_MASK  = 32'h8000_40b1;
  localparam logic [31:0] SEC_RESET = 32'h0000_0000;

  // ==========================================================
  // oscillator control fields
  localparam int OSC_CORE_BIT   = 1;
  localparam int OSC_PERIPH_BIT = 0;
  localparam int OSC_COUNT_W    = 16;
  localparam logic [1:0] OSC_CTRL_RESET = 2'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  num;
    logic [31:0] wdata;
  } ps_req_t;

  typedef struct packed {
    logic       ctl;
    logic [3:0] data;
  } rgmii_tx_t;

  typedef struct packed {
    logic global_debug_block;
    logic jtag_debug_block;
    logic secure_boot;
    logic pll_jtag_block;
    logic otp_redundancy;
  } security_ctl_t;

endpackage : tile_status_pkg

// *** ring_osc_counter.sv ***
// one ring oscillator counter, fed by an asynchronous oscillator output
`timescale 1ns/1ns
module ring_osc_counter #(
  parameter int COUNT_W = 16
) (
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  input  wire logic               osc_in,
  input  wire logic               run_in,
  output logic [COUNT_W-1:0]      count_out
);
  import tile_status_pkg::*;

  logic               sync1_q;
  logic               sync2_q;
  logic               sync3_q;
  logic               level_q;
  logic               rise;
  // power-up value is zero; a system reset leaves the count alone
  logic [COUNT_W-1:0] count_q = '0;

  // ==========================================================
  // three-stage synchroniser, a rising change counts once stages two and three agree
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= osc_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_q <= 1'b0;
    end else if (sync2_q == sync3_q) begin
      level_q <= sync3_q;
    end
  end

  assign rise = sync2_q & sync3_q & ~level_q;

  // ==========================================================
  // count keeps its value across reset, so it has no reset branch
  always_ff @(posedge core_clk_in) begin // R18
    if (run_in && rise) begin // R24
      count_q <= count_q + COUNT_W'(1);
    end
  end

  assign count_out = count_q;

  a_count_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // R24
    !run_in |=> count_q == $past(count_q))
    else $error("oscillator count moved while stopped");

  a_count_step: assert property (@(posedge core_clk_in) disable iff (rst_in) // R15
    (run_in && rise) |=> count_q == $past(count_q) + COUNT_W'(1))
    else $error("oscillator count missed an edge");

endmodule : ring_osc_counter

// *** tile_status_control_regs_test.sv ***
// self-checking bench for the tile status register bank
`timescale 1ns/1ns
module tile_status_control_regs_test;
  import tile_status_pkg::*;

  // ==========================================================
  // signals
  logic          clk;
  logic          rst;
  ps_req_t       req;
  logic [31:0]   rdata;
  logic          rvalid;
  rgmii_tx_t     tx_in;
  rgmii_tx_t     tx_out;
  logic          tx_clk;
  logic          port_en;
  logic          paused;
  logic          div_active;
  logic [7:0]    proc_num;
  logic          from_ram;
  logic          from_jtag;
  logic          core1_on;
  logic [1:0]    strap;
  logic          otp_load;
  logic [31:0]   otp_word;
  security_ctl_t sec_ctl;
  logic [3:0]    osc;
  logic [1:0]    osc_run;
  logic [15:0]   base [4];
  int            failures;
  int            compares;
  int            cycles;

  tile_status_control_regs dut (
    .core_clk_in            (clk),
    .rst_in                 (rst),
    .ps_req_in              (req),
    .ps_rdata_out           (rdata),
    .ps_rvalid_out          (rvalid),
    .rgmii_tx_in            (tx_in),
    .rgmii_tx_out           (tx_out),
    .rgmii_tx_clk_out       (tx_clk),
    .rgmii_port_en_out      (port_en),
    .threads_paused_in      (paused),
    .clk_div_active_out     (div_active),
    .processor_number_in    (proc_num),
    .boot_from_ram_in       (from_ram),
    .boot_from_jtag_in      (from_jtag),
    .second_core_powered_in (core1_on),
    .boot_pll_strap_in      (strap),
    .otp_load_in            (otp_load),
    .otp_word_in            (otp_word),
    .security_ctl_out       (sec_ctl),
    .osc_in                 (osc),
    .osc_run_out            (osc_run)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      give_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // num is the bare register number; the resource type byte never reaches this port
  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    req = '{wr: 1'b1, rd: 1'b0, num: n, wdata: d};
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] n, input logic [31:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, num: n, wdata: 32'h0000_0000};
    tick(1);
    req.rd = 1'b0;
    check({31'h0, rvalid}, 32'h0000_0001);
    check(rdata, exp);
    tick(1);
  endtask : rd_chk

  task automatic otp(input logic [31:0] w);
    otp_word = w;
    otp_load = 1'b1;
    tick(1);
    otp_load = 1'b0;
  endtask : otp

  task automatic osc_pulse(input logic [3:0] m);
    osc = m;
    tick(4);
    osc = 4'h0;
    tick(4);
  endtask : osc_pulse

  function automatic rgmii_tx_t pat(input int k);
    return rgmii_tx_t'(5'(k * 7 + 3));
  endfunction : pat

  // ==========================================================
  // scenarios
  task automatic test_reset_values;
    rd_chk(NUM_TILE_CTRL, 32'h0000_0000);
    rd_chk(NUM_SECURITY, 32'h0000_0000);
    rd_chk(NUM_OSC_CTRL, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0000);
    check(32'({port_en, tx_clk, div_active, osc_run}), 32'h0000_0000);
    check(32'(sec_ctl), 32'h0000_0000);
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_tile_control;
    wr(NUM_TILE_CTRL, 32'hffff_ffff);
    rd_chk(NUM_TILE_CTRL, 32'h03ff_ff30);
    check({31'h0, port_en}, 32'h0000_0001);
    wr(NUM_BOOT_STATUS, 32'hffff_ffff);
    wr(8'h04, 32'hffff_ffff);
    rd_chk(8'h04, 32'h0000_0000);
    wr(NUM_TILE_CTRL, 32'h0000_0010);
    check({31'h0, div_active}, 32'h0000_0001);
    wr(NUM_TILE_CTRL, 32'h0000_0030);
    check({31'h0, div_active}, 32'h0000_0000);
    paused = 1'b1;
    tick(1);
    check({31'h0, div_active}, 32'h0000_0001);
    wr(NUM_TILE_CTRL, 32'h0000_0020);
    check({31'h0, div_active}, 32'h0000_0000);
    paused = 1'b0;
    $display("test tile_control done");
  endtask : test_tile_control

  task automatic test_boot_status;
    rd_chk(NUM_BOOT_STATUS, 32'h005a_002a);
    proc_num  = 8'ha5;
    from_ram  = 1'b0;
    from_jtag = 1'b1;
    core1_on  = 1'b0;
    strap     = 2'h1;
    tick(4);
    // strap stays at the value captured after reset
    rd_chk(NUM_BOOT_STATUS, 32'h00a5_0006);
    strap = 2'h2;
    $display("test boot_status done");
  endtask : test_boot_status

  task automatic test_security;
    otp(32'h7fff_ffff);
    rd_chk(NUM_SECURITY, 32'h0000_40b1);
    check(32'(sec_ctl), 32'h0000_001f);
    rd_chk(NUM_BOOT_STATUS, 32'h00a5_0106);
    wr(NUM_SECURITY, 32'h8000_4001);
    rd_chk(NUM_SECURITY, 32'h8000_4001);
    check(32'(sec_ctl), 32'h0000_0018);
    wr(NUM_SECURITY, 32'h0000_0000);
    rd_chk(NUM_SECURITY, 32'h8000_4001);
    otp(32'h0000_0020);
    rd_chk(NUM_SECURITY, 32'h0000_0020);
    check(32'(sec_ctl), 32'h0000_0004);
    $display("test security done");
  endtask : test_security

  task automatic test_rgmii;
    int d;
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 0 : 3 * i - 1;
      wr(NUM_TILE_CTRL, (32'(d) << TXD_DELAY_LSB) | 32'h0000_0100);
      for (int k = 0; k < 10; k++) begin
        tx_in = pat(k);
        tick(1);
        if (k >= d) check(32'(tx_out), 32'(pat(k - d)));
      end
    end
    wr(NUM_TILE_CTRL, 32'h0000_0000);
    check(32'({tx_out, tx_clk, port_en}), 32'h0000_0000);
    $display("test rgmii done");
  endtask : test_rgmii

  task automatic test_tx_clock;
    int   dv;
    int   rises;
    int   highs;
    logic prev;
    for (int i = 0; i < 3; i++) begin
      dv = (i == 2) ? 6 : 3 + i;
      wr(NUM_TILE_CTRL, (32'(dv) << TXC_DIV_LSB) | 32'h0000_0100);
      tick(2 * (dv + 1));
      rises = 0;
      highs = 0;
      prev  = tx_clk;
      repeat (4 * (dv + 1)) begin
        tick(1);
        if (tx_clk === 1'b1 && prev === 1'b0) rises++;
        if (tx_clk === 1'b1) highs++;
        prev = tx_clk;
      end
      check(32'(rises), 32'h0000_0004);
      check(32'(highs), 32'(4 * ((dv >> 1) + 1)));
    end
    $display("test tx_clock done");
  endtask : test_tx_clock

  task automatic test_oscillators;
    wr(NUM_OSC_CTRL, 32'hffff_ffff);
    check({30'h0, osc_run}, 32'h0000_0003);
    rd_chk(NUM_OSC_CTRL, 32'h0000_0003);
    for (int s = 0; s < 4; s++) osc_pulse(4'hf << s);
    wr(NUM_OSC_CTRL, 32'h0000_0000);
    tick(10);
    for (int j = 0; j < 4; j++) begin
      req = '{wr: 1'b0, rd: 1'b1, num: 8'(NUM_OSC_COUNT0 + j), wdata: 32'h0000_0000};
      tick(1);
      req.rd = 1'b0;
      base[j] = rdata[15:0];
      // counts start at zero and counter j saw j+1 edges so far
      check(rdata, 32'(j + 1));
      tick(1);
    end
    // core run only: periph counters must ignore these edges
    wr(NUM_OSC_CTRL, 32'h0000_0002);
    check({30'h0, osc_run}, 32'h0000_0002);
    for (int s = 0; s < 4; s++) osc_pulse(4'hf << s);
    wr(NUM_OSC_CTRL, 32'h0000_0001);
    check({30'h0, osc_run}, 32'h0000_0001);
    for (int s = 0; s < 4; s++) osc_pulse(4'hf << s);
    wr(NUM_OSC_CTRL, 32'h0000_0000);
    osc_pulse(4'hf);
    tick(10);
    for (int j = 0; j < 4; j++) begin
      rd_chk(8'(NUM_OSC_COUNT0 + j), {16'h0, base[j] + 16'(j + 1)});
    end
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(4);
    for (int j = 0; j < 4; j++) begin
      rd_chk(8'(NUM_OSC_COUNT0 + j), {16'h0, base[j] + 16'(j + 1)});
    end
    $display("test oscillators done");
  endtask : test_oscillators

  // ==========================================================
  // verdict
  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rst       = 1'b1;
    req       = '0;
    tx_in     = '0;
    paused    = 1'b0;
    proc_num  = 8'h5a;
    from_ram  = 1'b1;
    from_jtag = 1'b0;
    core1_on  = 1'b1;
    strap     = 2'h2;
    otp_load  = 1'b0;
    otp_word  = 32'h0000_0000;
    osc       = 4'h0;
    failures  = 0;
    compares  = 0;
    cycles    = 0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(4);
    test_reset_values();
    test_tile_control();
    test_boot_status();
    test_security();
    test_rgmii();
    test_tx_clock();
    test_oscillators();
    give_verdict();
  end

endmodule : tile_status_control_regs_test
